// [include/vsp_regs.vh]
`ifndef VSP_REGS_VH
`define VSP_REGS_VH
// ****************************************************
// Register map (byte addresses)
// ****************************************************
`define VSP_CTRL_OFS        4'h0
`define VSP_STATUS_OFS      4'h4
`define VSP_TRS_CNT_OFS     4'h8
`define VSP_FIELD_CNT_OFS   4'hC
// Control fields and reset value
`define VSP_CTRL_PLAIN_BIT  0
`define VSP_CTRL_FAULT_BIT  1
`define VSP_CTRL_RST        2'h0
// Status fields
`define VSP_ST_LOCK_BIT     0
`define VSP_ST_RUN_BIT      1
`define VSP_ST_SELF_BIT     2
`define VSP_ST_PASS_BIT     3
`define VSP_ST_FAIL_BIT     4
`define VSP_ST_CODE_LSB     8
// AXI responses
`define VSP_RESP_OKAY       2'h0
`define VSP_RESP_SLVERR     2'h2
// ****************************************************
// Timing
// ****************************************************
`define VSP_CLK_MHZ         100
`define VSP_LOCK_TIME_US    75
`define VSP_WORD_DIV        4'hA
`define VSP_PASS_FIELDS     2'h2
`define VSP_LINES_NTSC      262
`define VSP_LINES_PAL       313
// Words per line for each standard and raster
`define VSP_WORDS_NTSC_43   12'h6B4
`define VSP_WORDS_NTSC_169  12'h8F0
`define VSP_WORDS_PAL_43    12'h6C0
`define VSP_WORDS_PAL_169   12'h900
// Timing reference words
`define VSP_TRS_ONES        10'h3FF
`define VSP_TRS_ZERO        10'h000
`define VSP_TRS_XYZ         10'h274
// Code fields
`define VSP_PAT_BLACK       2'h0
`define VSP_PAT_PLL         2'h1
`define VSP_PAT_EQ          2'h2
`define VSP_PAT_BARS        2'h3
`endif

// [rtl/vsp_pattern.v]
`default_nettype none
`include "vsp_regs.vh"
// ****************************************************
// Pattern word source
// ****************************************************
module vsp_pattern
(
	input  wire       clock_i,
	input  wire       rst_n_i,
	input  wire       word_en_i,
	input  wire       run_i,
	input  wire [3:0] code_i,
	output reg  [9:0] word_o,
	output reg        line_end_o
);
	reg  [11:0] sample_reg;
	reg  [11:0] bar_cnt_reg;
	reg  [2:0]  bar_reg;
	wire [11:0] line_len;
	wire [11:0] bar_len;

	// Line length from standard (bit3) and raster (bit2)
	function [11:0] words_per_line;
		input [1:0] fmt;
		begin
			case (fmt)
				2'h0:    words_per_line = `VSP_WORDS_NTSC_43;
				2'h1:    words_per_line = `VSP_WORDS_NTSC_169;
				2'h2:    words_per_line = `VSP_WORDS_PAL_43;
				default: words_per_line = `VSP_WORDS_PAL_169;
			endcase
		end
	endfunction

	// Bar levels: index, phase (luma odd, Cb 0, Cr 2)
	function [9:0] bar_level;
		input [2:0] idx;
		input [1:0] ph;
		begin
			case ({ph[0], ph[1]})
				2'b10, 2'b11: bar_level = 10'h2D0 - {idx, 6'h0} + {4'h0, idx, 3'h0};
				2'b00:        bar_level = idx[0] ? 10'h0B0 : 10'h2A8;
				default:      bar_level = idx[1] ? 10'h330 : 10'h0D0;
			endcase
		end
	endfunction

	assign line_len = words_per_line({code_i[3], code_i[2]});
	assign bar_len  = {3'h0, line_len[11:3]};

	// Sample and bar counters; bars switch abruptly at boundaries
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sample_reg  <= 12'h000;
			bar_cnt_reg <= 12'h000;
			bar_reg     <= 3'h0;
			line_end_o  <= 1'b0;
		end
		else if (!run_i)
		begin
			sample_reg  <= 12'h000;
			bar_cnt_reg <= 12'h000;
			bar_reg     <= 3'h0;
			line_end_o  <= 1'b0;
		end
		else if (word_en_i)
		begin
			line_end_o <= (sample_reg == line_len - 12'h001);
			if (sample_reg == line_len - 12'h001)
			begin
				sample_reg  <= 12'h000;
				bar_cnt_reg <= 12'h000;
				bar_reg     <= 3'h0;
			end
			else
			begin
				sample_reg <= sample_reg + 12'h001;
				if (bar_cnt_reg == bar_len - 12'h001 && bar_reg != 3'h7)
				begin
					bar_cnt_reg <= 12'h000;
					bar_reg     <= bar_reg + 3'h1;
				end
				else
					bar_cnt_reg <= bar_cnt_reg + 12'h001;
			end
		end
		else
			line_end_o <= 1'b0;
	end

	// Word select: timing reference, then pattern body
	always @*
	begin
		if (sample_reg == 12'h000)
			word_o = `VSP_TRS_ONES;
		else if (sample_reg < 12'h003)
			word_o = `VSP_TRS_ZERO;
		else if (sample_reg == 12'h003)
			word_o = `VSP_TRS_XYZ;
		else
		begin
			case (code_i[1:0])
				`VSP_PAT_BLACK: word_o = sample_reg[0] ? 10'h040 : 10'h200;
				`VSP_PAT_PLL:   word_o = sample_reg[0] ? 10'h110 : 10'h200;
				`VSP_PAT_EQ:    word_o = sample_reg[0] ? 10'h198 : 10'h300;
				default:        word_o = bar_level(bar_reg, sample_reg[1:0]);
			endcase
		end
	end
endmodule
`default_nettype wire

// [rtl/vsp_self_test.v]
`default_nettype none
`include "vsp_regs.vh"
module vsp_self_test
#(
	parameter LOCK_CYCLES      = (`VSP_LOCK_TIME_US * `VSP_CLK_MHZ),
	parameter FIELD_LINES_NTSC = `VSP_LINES_NTSC,
	parameter FIELD_LINES_PAL  = `VSP_LINES_PAL
)
(
	input  wire        clock_i,
	input  wire        rst_n_i,
	input  wire [9:0]  parallel_in_i,
	input  wire        pattern_gen_enable_i,
	input  wire        sync_detect_enable_n_i,
	output reg         lock_detect_o,
	output reg         self_test_result_o,
	output reg         serial_out_o,
	output reg         serial_out_n_o,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	// ****************************************************
	// Reset release and clock division
	// ****************************************************
	reg        rst_meta_reg;
	reg        rst_n;
	reg  [3:0] div_reg;
	reg        word_en_reg;
	reg        word_en_d_reg;
	reg [12:0] lock_cnt_reg;
	reg        locked_reg;

	// Two-stage release of the asynchronous reset
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// Word strobe once every ten bit periods
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_reg       <= 4'h0;
			word_en_reg   <= 1'b0;
			word_en_d_reg <= 1'b0;
		end
		else
		begin
			div_reg       <= (div_reg == `VSP_WORD_DIV - 4'h1) ? 4'h0 : div_reg + 4'h1;
			word_en_reg   <= (div_reg == `VSP_WORD_DIV - 4'h1);
			word_en_d_reg <= word_en_reg;
		end
	end

	// Lock model: fixed acquisition time after reset, high-true
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lock_cnt_reg  <= 13'h0000;
			locked_reg    <= 1'b0;
			lock_detect_o <= 1'b0;
		end
		else
		begin
			if (!locked_reg)
				lock_cnt_reg <= lock_cnt_reg + 13'h0001;
			if (lock_cnt_reg == LOCK_CYCLES[12:0] - 13'h0001)
				locked_reg <= 1'b1;
			lock_detect_o <= locked_reg;
		end
	end

	// ****************************************************
	// Mode control
	// ****************************************************
	reg  [1:0] ctrl_reg;
	reg        run_reg;
	reg        self_reg;
	reg  [3:0] code_reg;
	wire       code_ok;
	wire       start;

	// Self-test runs on NTSC bars or PAL PLL codes unless plain mode set
	function is_self_code;
		input [3:0] c;
		begin
			is_self_code = (!c[3] && c[1:0] == `VSP_PAT_BARS) || (c[3] && c[1:0] == `VSP_PAT_PLL);
		end
	endfunction

	// Upper bits must be zero; pulled-down pins read zero when open
	assign code_ok = (parallel_in_i[9:4] == 6'h00);
	assign start   = pattern_gen_enable_i && locked_reg && !run_reg && code_ok;

	// Capture code on start, stop on enable low or lost lock
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_reg  <= 1'b0;
			self_reg <= 1'b0;
			code_reg <= 4'h0;
		end
		else if (start)
		begin
			run_reg  <= 1'b1;
			code_reg <= parallel_in_i[3:0];
			self_reg <= is_self_code(parallel_in_i[3:0]) && !ctrl_reg[`VSP_CTRL_PLAIN_BIT];
		end
		else if (!pattern_gen_enable_i || !locked_reg)
		begin
			run_reg  <= 1'b0;
			self_reg <= 1'b0;
		end
	end

	// ****************************************************
	// Word source and serializer
	// ****************************************************
	wire [9:0] pat_word;
	wire       line_end;
	wire [9:0] tx_word;
	reg  [9:0] shift_reg;

	vsp_pattern u_pattern
	(
		.clock_i    (clock_i),
		.rst_n_i    (rst_n),
		.word_en_i  (word_en_reg),
		.run_i      (run_reg),
		.code_i     (code_reg),
		.word_o     (pat_word),
		.line_end_o (line_end)
	);

	// Pattern replaces the unregistered parallel input while running
	assign tx_word = run_reg ? pat_word : parallel_in_i;

	// Bits leave least significant first; output frozen without lock
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_reg      <= 10'h000;
			serial_out_o   <= 1'b0;
			serial_out_n_o <= 1'b1;
		end
		else if (!locked_reg)
		begin
			shift_reg      <= 10'h000;
			serial_out_o   <= 1'b0;
			serial_out_n_o <= 1'b1;
		end
		else
		begin
			shift_reg      <= word_en_reg ? tx_word : {1'b0, shift_reg[9:1]};
			serial_out_o   <= shift_reg[0];
			serial_out_n_o <= ~shift_reg[0];
		end
	end

	// ****************************************************
	// Self-test checker
	// ****************************************************
	reg  [9:0] rx_reg;
	reg  [9:0] sent_cur_reg;
	reg  [9:0] sent_prev_reg;
	reg  [1:0] armed_reg;
	reg  [8:0] line_cnt_reg;
	reg  [1:0] field_cnt_reg;
	reg        fail_reg;
	reg        pass_reg;
	wire [8:0] field_lines;

	assign field_lines = code_reg[3] ? FIELD_LINES_PAL[8:0] : FIELD_LINES_NTSC[8:0];

	// Loop the serial stream back and rebuild each word one cycle after reload
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_reg        <= 10'h000;
			sent_cur_reg  <= 10'h000;
			sent_prev_reg <= 10'h000;
			armed_reg     <= 2'h0;
		end
		else
		begin
			rx_reg <= {serial_out_o, rx_reg[9:1]};
			if (!self_reg)
				armed_reg <= 2'h0;
			else if (word_en_reg && armed_reg != 2'h3)
				armed_reg <= armed_reg + 2'h1;
			if (word_en_reg)
			begin
				sent_cur_reg  <= tx_word;
				sent_prev_reg <= sent_cur_reg;
			end
		end
	end

	// Compare, count fields, decide pass or fail
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			line_cnt_reg  <= 9'h000;
			field_cnt_reg <= 2'h0;
			fail_reg      <= 1'b0;
			pass_reg      <= 1'b0;
		end
		else if (!self_reg)
		begin
			line_cnt_reg  <= 9'h000;
			field_cnt_reg <= 2'h0;
			fail_reg      <= 1'b0;
			pass_reg      <= 1'b0;
		end
		else
		begin
			if (word_en_d_reg && armed_reg == 2'h3 &&
				(({serial_out_o, rx_reg[9:1]} ^ {9'h000, ctrl_reg[`VSP_CTRL_FAULT_BIT]}) != sent_prev_reg))
				fail_reg <= 1'b1;
			if (line_end)
			begin
				if (line_cnt_reg == field_lines - 9'h001)
				begin
					line_cnt_reg <= 9'h000;
					if (field_cnt_reg != `VSP_PASS_FIELDS)
						field_cnt_reg <= field_cnt_reg + 2'h1;
				end
				else
					line_cnt_reg <= line_cnt_reg + 9'h001;
			end
			if (field_cnt_reg == `VSP_PASS_FIELDS && !fail_reg)
				pass_reg <= 1'b1;
		end
	end

	// Result pin: high only on pass with no error seen
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
			self_test_result_o <= 1'b0;
		else
			self_test_result_o <= pass_reg && !fail_reg;
	end

	// ****************************************************
	// Timing reference detection
	// ****************************************************
	reg [9:0]  hist1_reg;
	reg [9:0]  hist0_reg;
	reg [15:0] trs_cnt_reg;

	// Counts 3FF 000 000 prefixes; active-low enable
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hist1_reg   <= 10'h000;
			hist0_reg   <= 10'h000;
			trs_cnt_reg <= 16'h0000;
		end
		else if (word_en_reg && locked_reg)
		begin
			hist1_reg <= hist0_reg;
			hist0_reg <= tx_word;
			if (!sync_detect_enable_n_i && hist1_reg == `VSP_TRS_ONES &&
				hist0_reg == `VSP_TRS_ZERO && tx_word == `VSP_TRS_ZERO)
				trs_cnt_reg <= trs_cnt_reg + 16'h0001;
		end
	end

	// ****************************************************
	// AXI4-Lite slave
	// ****************************************************
	wire        wr_go;
	wire        rd_go;
	wire [31:0] status_word;

	// Address and data taken together, one write outstanding
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	assign status_word = {20'h00000, code_reg, 3'h0, fail_reg, pass_reg, self_reg, run_reg, locked_reg};

	// Write channel; unmapped offsets answer SLVERR
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `VSP_RESP_OKAY;
			ctrl_reg      <= `VSP_CTRL_RST;
		end
		else
		begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				if (s_axi_awaddr == `VSP_CTRL_OFS)
				begin
					s_axi_bresp <= `VSP_RESP_OKAY;
					if (s_axi_wstrb[0])
						ctrl_reg <= s_axi_wdata[1:0];
				end
				else if (s_axi_awaddr == `VSP_STATUS_OFS || s_axi_awaddr == `VSP_TRS_CNT_OFS ||
					s_axi_awaddr == `VSP_FIELD_CNT_OFS)
					s_axi_bresp <= `VSP_RESP_OKAY;
				else
					s_axi_bresp <= `VSP_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel
	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `VSP_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= rd_go;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `VSP_RESP_OKAY;
				case (s_axi_araddr)
					`VSP_CTRL_OFS:      s_axi_rdata <= {30'h0000_0000, ctrl_reg};
					`VSP_STATUS_OFS:    s_axi_rdata <= status_word;
					`VSP_TRS_CNT_OFS:   s_axi_rdata <= {16'h0000, trs_cnt_reg};
					`VSP_FIELD_CNT_OFS: s_axi_rdata <= {21'h00_0000, field_cnt_reg, line_cnt_reg};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `VSP_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [tb/vsp_self_test_monitor.sv]
`default_nettype none
// *****
// Port checks of the self-test block
// *****
module vsp_self_test_monitor
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic pattern_gen_enable_i,
	input wire logic lock_detect_o,
	input wire logic self_test_result_o,
	input wire logic serial_out_o,
	input wire logic serial_out_n_o,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Read taken, then answered in the same cycle
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_answer;
		s_axi_rvalid;
	endsequence
	pair_compl_a: assert property (serial_out_n_o == !serial_out_o)
		else $error("serial pair not complementary");
	unlock_static_a: assert property (!lock_detect_o ##1 !lock_detect_o |-> $stable(serial_out_o))
		else $error("serial line moved while unlocked");
	lock_hold_a: assert property (lock_detect_o |=> lock_detect_o)
		else $error("lock dropped");
	rise_enabled_a: assert property ($rose(self_test_result_o) |-> $past(pattern_gen_enable_i))
		else $error("result rose without enable");
	stop_clear_a: assert property (!pattern_gen_enable_i [*4] |-> !self_test_result_o)
		else $error("result high after enable low");
	read_answer_a: assert property (rd_taken |-> rd_answer)
		else $error("read taken without answer");
	write_answer_a: assert property (s_axi_awready |-> s_axi_wready && s_axi_bvalid)
		else $error("write taken without response");
	resp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	data_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not released");
endmodule
bind vsp_self_test vsp_self_test_monitor vsp_self_test_monitor_i
(
	.clock_i, .rst_n_i, .pattern_gen_enable_i, .lock_detect_o, .self_test_result_o, .serial_out_o,
	.serial_out_n_o, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// [tb/vsp_rx_model.sv]
`default_nettype none
// *****
// Cable receiver: finds line openings
// *****
module vsp_rx_model
(
	input wire logic  clock_i,
	input wire logic  serial_i,
	input wire logic  serial_n_i,
	output var logic  line_start_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [39:0] shift_reg;
	// Bits arrive LSB first, so new bits enter at the top
	always @(posedge clock_i)
		shift_reg <= {serial_i, shift_reg[39:1]};
	// Broken pair counts as no line opening
	assign line_start_o = (shift_reg == {10'h274, 10'h000, 10'h000, 10'h3FF}) && (serial_n_i == !serial_i);
endmodule
`default_nettype wire

// [tb/video_serializer_self_test_pattern_gen_tb.sv]
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module video_serializer_self_test_pattern_gen_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FIELD = 1716 * 2 * 10;	// Two-line NTSC field, in clocks
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [9:0]  par_in  = 10'h000;
	logic        enable  = 1'b0;
	logic        sync_n  = 1'b1;
	logic [3:0]  awaddr  = 4'h0;
	logic [3:0]  araddr  = 4'h0;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	wire         lock, result, ser, ser_n, awready, wready, bvalid, arready, rvalid, line_start;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	logic [33:0] exp_q[$], msk_q[$];
	logic [33:0] e_w, m_w;
	logic        seen_line = 1'b0;
	logic        sf;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n, c;
	integer      seed = 32'hf94e;
	vsp_self_test #(.LOCK_CYCLES(20), .FIELD_LINES_NTSC(2), .FIELD_LINES_PAL(2)) vsp_self_test_i
	(
		.clock_i, .rst_n_i, .parallel_in_i(par_in), .pattern_gen_enable_i(enable), .sync_detect_enable_n_i(sync_n),
		.lock_detect_o(lock), .self_test_result_o(result), .serial_out_o(ser), .serial_out_n_o(ser_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	vsp_rx_model vsp_rx_model_i (.clock_i, .serial_i(ser), .serial_n_i(ser_n), .line_start_o(line_start));
	always #5 clock_i = ~clock_i;
	// Sticky note of a line opening at the receiver
	always @(posedge clock_i)
		if (line_start === 1'b1) seen_line <= 1'b1;
	// Oldest note against each read answer
	always @(posedge clock_i)
		if (rvalid === 1'b1 && rready && exp_q.size() > 0)
		begin
			e_w = exp_q.pop_front();
			m_w = msk_q.pop_front();
			`CHK("read word", e_w & m_w, {rresp, rdata} & m_w)
		end
	// Hang guard, well above the longest wait
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			n_errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Both channels offered together, each released when taken
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clock_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK("write response", er, bresp)
	endtask
	// Expectation noted first; the compare process checks the answer
	task automatic axi_read(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock_i);
			if (arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	// *****
	// Stimulus
	// *****
	initial
	begin
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		`CHK("lock early", 1'b0, lock)
		for (n = 0; n < 40 && lock !== 1'b1; n++) @(posedge clock_i);
		`CHK("lock", 1'b1, lock)
		axi_read(4'h0, 34'h0_0000_0000, 34'h3_0000_0003);
		// Upper bits not zero: start must be ignored
		par_in <= {6'($random(seed)) | 6'h01, 4'h3};
		enable <= 1'b1;
		repeat (8) @(posedge clock_i);
		axi_read(4'h4, 34'h0_0000_0001, 34'h3_0000_000F);
		enable <= 1'b0;
		$display("test refused start done");
		// Every code starts; self-test only on its own codes
		for (c = 0; c < 16; c++)
		begin
			repeat (4) @(posedge clock_i);
			par_in <= 10'(c);
			enable <= 1'b1;
			sf = (c[1:0] == 2'h3 && !c[3]) || (c[1:0] == 2'h1 && c[3]);
			repeat (6) @(posedge clock_i);
			axi_read(4'h4, {22'h0, 4'(c), 5'h0, sf, 2'b11}, 34'h3_0000_0F07);
			enable <= 1'b0;
		end
		$display("test code table done");
		repeat (4) @(posedge clock_i);
		par_in <= 10'h000;
		// Flush sync history with idle words; detection held off so far
		repeat (30) @(posedge clock_i);
		axi_read(4'h8, 34'h0_0000_0000, 34'h3_0000_FFFF);
		sync_n <= 1'b0;
		enable <= 1'b1;
		seen_line <= 1'b0;
		@(posedge clock_i);
		for (n = 0; n < 2000 && seen_line !== 1'b1; n++) @(posedge clock_i);
		`CHK("line start", 1'b1, seen_line)
		enable <= 1'b0;
		repeat (4) @(posedge clock_i);
		axi_read(4'h4, 34'h0_0000_0001, 34'h3_0000_0003);
		axi_read(4'h8, 34'h0_0000_0001, 34'h3_0000_FFFF);
		$display("test pattern mode done");
		par_in <= 10'h003;
		enable <= lock;
		seen_line <= 1'b0;
		@(posedge clock_i);
		for (n = 0; n < 2 * FIELD + FIELD / 2 && result !== 1'b1; n++) @(posedge clock_i);
		`CHK("pass time", 1'b1, (n > 2 * FIELD - FIELD / 4 && n < 2 * FIELD + FIELD / 2))
		`CHK("serial during test", 1'b1, seen_line)
		axi_read(4'h4, 34'h0_0000_000F, 34'h3_0000_001F);
		enable <= 1'b0;
		repeat (4) @(posedge clock_i);
		`CHK("result cleared", 1'b0, result)
		$display("test self-test pass done");
		axi_write(4'h0, 32'h0000_0002, 2'h0);
		axi_read(4'h0, 34'h0_0000_0002, 34'h3_0000_0003);
		par_in <= 10'h009;
		enable <= 1'b1;
		repeat (2000) @(posedge clock_i);
		`CHK("result under fault", 1'b0, result)
		axi_read(4'h4, 34'h0_0000_0017, 34'h3_0000_001F);
		enable <= 1'b0;
		axi_write(4'h0, 32'h0000_0000, 2'h0);
		$display("test self-test fail done");
		axi_read(4'h2, 34'h2_0000_0000, 34'h3_FFFF_FFFF);
		axi_write(4'h2, 32'hFFFF_FFFF, 2'h2);
		$display("test unmapped access done");
		repeat (2) @(posedge clock_i);
		end_sim();
	end
endmodule
`default_nettype wire
